// >>> design/event_flag.v
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// one hardware-set flag: set wins over clear
module event_flag (
   input  wire i_clk,
   input  wire i_arst_n,
   input  wire i_set,
   input  wire i_clear,
   output reg  o_flag
);
   // sticky bit
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_flag <= 1'b0;
      end else if (i_set) begin
         o_flag <= 1'b1;
      end else if (i_clear) begin
         o_flag <= 1'b0;
      end
   end
endmodule // event_flag
`default_nettype wire

// >>> design/poll_timer.v
`timescale 1ns/1ps
`default_nettype none
`include "usb_event_defines.vh"
// ==================================================
// interval / nak-limit counter in frame ticks
module poll_timer (
   input  wire       i_clk,
   input  wire       i_arst_n,
   input  wire       i_frame_tick,
   input  wire       i_restart,
   input  wire [1:0] i_proto,
   input  wire [1:0] i_speed,
   input  wire [7:0] i_interval,
   input  wire       i_nak,
   output reg        o_poll,
   output reg        o_nak_timeout,
   output reg        o_cfg_invalid
);
   reg  [15:0] count;
   reg  [16:0] period;
   reg         use_exp;
   reg         bulk;
   reg         valid;
   wire [4:0]  shift = i_interval[4:0] - 5'd1;

   // decode interval rules per transfer type
   always @* begin
      bulk    = (i_proto == `PROTO_BULK);
      use_exp = (i_proto == `PROTO_ISO) || bulk ||
                ((i_proto == `PROTO_INTR) && (i_speed == `SPEED_HIGH));
      period  = 17'h0_0000;
      valid   = 1'b1;
      if (i_proto == `PROTO_CTRL) begin
         valid = 1'b1;
      end else if (use_exp) begin
         valid  = bulk ? (i_interval <= `EXP_MAX)
                       : (i_interval != 8'h00 && i_interval <= `EXP_MAX);
         period = (i_interval >= 8'h01 && i_interval <= `EXP_MAX) ?
                  (17'h0_0001 << shift) : 17'h0_0001;
      end else begin
         valid  = (i_interval != 8'h00);
         period = {9'h000, i_interval};
      end
   end

   // count frames; nak runs reset on any non-nak reply
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         count         <= 16'h0000;
         o_poll        <= 1'b0;
         o_nak_timeout <= 1'b0;
         o_cfg_invalid <= 1'b0;
      end else begin
         o_poll        <= 1'b0;
         o_nak_timeout <= 1'b0;
         o_cfg_invalid <= ~valid;
         if (i_restart || (bulk && !i_nak)) begin
            count <= 16'h0000;
         end else if (i_frame_tick && valid && i_proto != `PROTO_CTRL) begin
            if ({1'b0, count} + 17'h0_0001 >= period) begin
               count <= 16'h0000;
               if (bulk) begin
                  o_nak_timeout <= (i_interval >= 8'h02);
               end else begin
                  o_poll <= 1'b1;
               end
            end else begin
               count <= count + 16'h0001;
            end
         end
      end
   end
endmodule // poll_timer
`default_nettype wire

// >>> design/usb_event_block.v
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "usb_event_defines.vh"
module usb_event_block #(
   parameter ADDR_W = 12
) (
   input  wire              i_clk,
   input  wire              i_arst_n,
   // apb slave
   input  wire              i_psel,
   input  wire              i_penable,
   input  wire              i_pwrite,
   input  wire [ADDR_W-1:0] i_paddr,
   input  wire [31:0]       i_pwdata,
   input  wire [3:0]        i_pstrb,
   output reg  [31:0]       o_prdata,
   output reg               o_pready,
   output reg               o_pslverr,
   // bus events, one-cycle pulses; host mode and session active are levels
   input  wire              i_host_mode,
   input  wire              i_session_active,
   input  wire              i_vbus_below_valid,
   input  wire              i_session_req_seen,
   input  wire              i_detach_seen,
   input  wire              i_session_end,
   input  wire              i_attach_seen,
   input  wire              i_frame_start,
   input  wire              i_bus_reset_seen,
   input  wire              i_babble_seen,
   input  wire              i_resume_seen,
   input  wire              i_suspend_seen,
   // rx endpoint traffic
   input  wire              i_rx_nak,
   input  wire              i_rx_restart,
   output reg  [1:0]        o_rx_speed,
   output reg  [1:0]        o_rx_proto,
   output reg  [3:0]        o_rx_target_ep,
   output reg               o_rx_poll,
   output reg               o_rx_nak_timeout,
   output reg               o_usb_irq,
   output reg               o_irq
);
   // ==================================================
   // state
   reg  [7:0]  irq_enable;
   reg  [7:0]  rx_ep_irq_enable;
   reg  [15:0] rx_cfg;
   reg  [4:0]  irq_mask;
   reg  [4:0]  irq_status;
   reg  [4:0]  next_irq_status;
   reg  [31:0] next_prdata;
   reg         next_pslverr;
   wire [7:0]  flags;
   wire [7:0]  flag_set;
   wire        poll_pulse;
   wire        nak_pulse;
   wire        cfg_invalid;
   wire        vbus_drop;
   wire        wr_acc;
   wire        rd_acc;

   assign wr_acc = i_psel && i_penable && i_pwrite && !o_pready;
   assign rd_acc = i_psel && i_penable && !i_pwrite && !o_pready;
   assign vbus_drop = i_vbus_below_valid && i_session_active;

   // ==================================================
   // event sources, ordered bit 7 (vbus) down to bit 0 (suspend)
   assign flag_set[7] = vbus_drop;
   assign flag_set[6] = i_session_req_seen;
   assign flag_set[5] = i_host_mode ? i_detach_seen : i_session_end;
   assign flag_set[4] = i_host_mode && i_attach_seen;
   assign flag_set[3] = i_frame_start;
   assign flag_set[2] = i_host_mode ? i_babble_seen : i_bus_reset_seen;
   assign flag_set[1] = i_resume_seen;
   assign flag_set[0] = i_suspend_seen;

   // flags clear when software reads the register; a set in that cycle wins
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_flag
         event_flag u_flag (
            .i_clk    (i_clk),
            .i_arst_n (i_arst_n),
            .i_set    (flag_set[g]),
            .i_clear  (rd_acc && i_paddr == `ADDR_EVENT_CTRL_STATUS),
            .o_flag   (flags[g])
         );
      end
   endgenerate

   // ==================================================
   // receive interval timer
   poll_timer u_poll (
      .i_clk         (i_clk),
      .i_arst_n      (i_arst_n),
      .i_frame_tick  (i_frame_start),
      .i_restart     (i_rx_restart),
      .i_proto       (rx_cfg[`PROTO_HI:`PROTO_LO]),
      .i_speed       (rx_cfg[`SPEED_HI:`SPEED_LO]),
      .i_interval    (rx_cfg[`INTERV_HI:`INTERV_LO]),
      .i_nak         (i_rx_nak),
      .o_poll        (poll_pulse),
      .o_nak_timeout (nak_pulse),
      .o_cfg_invalid (cfg_invalid)
   );

   // ==================================================
   // block interrupt status: poll, nak timeout, bad config,
   // reserved speed code, usb event irq
   always @* begin
      next_irq_status = irq_status;
      if (wr_acc && i_paddr == `ADDR_IRQ_STATUS && i_pstrb[0]) begin
         next_irq_status = irq_status & ~i_pwdata[4:0]; // write one clears
      end
      next_irq_status = next_irq_status | {
         |(flags & irq_enable),
         rx_cfg[`SPEED_HI:`SPEED_LO] == 2'b00 &&
            rx_cfg[`PROTO_HI:`PROTO_LO] != `PROTO_CTRL,
         cfg_invalid, nak_pulse, poll_pulse};            // set wins
   end

   // ==================================================
   // register writes, byte strobes honoured
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         irq_enable       <= `EN_RESET;
         rx_ep_irq_enable <= `RXEP_RESET;
         rx_cfg           <= `RXCFG_RESET;
         irq_mask         <= 5'h00;
         irq_status       <= 5'h00;
      end else begin
         irq_status <= next_irq_status;
         if (wr_acc && i_paddr == `ADDR_EVENT_CTRL_STATUS) begin
            if (i_pstrb[3]) begin
               irq_enable <= i_pwdata[`EN_HI:`EN_LO];
            end
            if (i_pstrb[0]) begin
               rx_ep_irq_enable <= {i_pwdata[`RXEP_HI:1], 1'b0};
            end
         end else if (wr_acc && i_paddr == `ADDR_RX_EP_CONFIG) begin
            if (i_pstrb[1]) begin
               rx_cfg[15:8] <= i_pwdata[15:8];
            end
            if (i_pstrb[0]) begin
               rx_cfg[7:0] <= i_pwdata[7:0];
            end
         end else if (wr_acc && i_paddr == `ADDR_IRQ_MASK) begin
            if (i_pstrb[0]) begin
               irq_mask <= i_pwdata[4:0];
            end
         end
      end
   end

   // ==================================================
   // read mux; unmapped addresses answer pslverr with zero data
   always @* begin
      next_prdata  = 32'h0000_0000;
      next_pslverr = 1'b0;
      if (i_paddr == `ADDR_EVENT_CTRL_STATUS) begin
         next_prdata = {irq_enable, flags, 8'h00, rx_ep_irq_enable};
      end else if (i_paddr == `ADDR_RX_EP_CONFIG) begin
         next_prdata = {16'h0000, rx_cfg};
      end else if (i_paddr == `ADDR_IRQ_STATUS) begin
         next_prdata = {27'h000_0000, irq_status};
      end else if (i_paddr == `ADDR_IRQ_MASK) begin
         next_prdata = {27'h000_0000, irq_mask};
      end else if (i_paddr == `ADDR_POLL_STATUS) begin
         next_prdata = {30'h0000_0000, cfg_invalid, o_rx_poll};
      end else begin
         next_pslverr = 1'b1;
      end
   end

   // ==================================================
   // one wait state: pready for one cycle in the access phase
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_prdata         <= 32'h0000_0000;
         o_pready         <= 1'b0;
         o_pslverr        <= 1'b0;
         o_rx_speed       <= 2'b00;
         o_rx_proto       <= 2'b00;
         o_rx_target_ep   <= 4'h0;
         o_rx_poll        <= 1'b0;
         o_rx_nak_timeout <= 1'b0;
         o_usb_irq        <= 1'b0;
         o_irq            <= 1'b0;
      end else begin
         o_pready  <= i_psel && i_penable && !o_pready;
         o_pslverr <= i_psel && i_penable && !o_pready && next_pslverr;
         if (rd_acc) begin
            o_prdata <= next_prdata;
         end
         o_rx_speed       <= rx_cfg[`SPEED_HI:`SPEED_LO];
         o_rx_proto       <= rx_cfg[`PROTO_HI:`PROTO_LO];
         o_rx_target_ep   <= rx_cfg[`TARGET_EP_HI:`TARGET_EP_LO];
         o_rx_poll        <= poll_pulse;
         o_rx_nak_timeout <= nak_pulse;
         // level irq: any enabled event flag
         o_usb_irq <= |(flags & irq_enable);
         o_irq     <= |(next_irq_status & irq_mask);
      end
   end
endmodule // usb_event_block
`default_nettype wire

// >>> design/usb_event_defines.vh
`ifndef USB_EVENT_DEFINES_VH
`define USB_EVENT_DEFINES_VH
// ==================================================
// register byte addresses
`define ADDR_EVENT_CTRL_STATUS 12'h000
`define ADDR_RX_EP_CONFIG      12'h004
`define ADDR_IRQ_STATUS        12'h008
`define ADDR_IRQ_MASK          12'h00C
`define ADDR_POLL_STATUS       12'h010
// ==================================================
// field positions
`define EN_HI          31
`define EN_LO          24
`define FLAG_HI        23
`define FLAG_LO        16
`define RXEP_HI        7
`define RXEP_LO        0
`define INTERV_HI      15
`define INTERV_LO      8
`define SPEED_HI       7
`define SPEED_LO       6
`define PROTO_HI       5
`define PROTO_LO       4
`define TARGET_EP_HI   3
`define TARGET_EP_LO   0
// ==================================================
// reset values
`define EN_RESET       8'h06
`define RXEP_RESET     8'hFE
`define RXCFG_RESET    16'h0000
// ==================================================
// encodings
`define SPEED_LOW      2'b11
`define SPEED_FULL     2'b10
`define SPEED_HIGH     2'b01
`define PROTO_INTR     2'b11
`define PROTO_BULK     2'b10
`define PROTO_ISO      2'b01
`define PROTO_CTRL     2'b00
`define EXP_MAX        8'h10
// ==================================================
// timing: 20 MHz clock, one frame tick comes from outside
`define CLK_PERIOD_NS  50
`endif

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, host = 1'b0;
   logic fire = 1'b0, frames = 1'b0, nak = 1'b0, restart = 1'b0, sess = 1'b1, er;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd, v;
   logic [3:0]  pstrb = 4'h0, sel = 4'h0, tgt_ep;
   logic [8:0]  ev;
   logic [1:0]  speed, proto;
   logic [7:0]  en, xf;
   logic        pready, pslverr, frame, poll, nto, usb_irq, irq;
   integer      fail_count = 0, checks_done = 0, seed = 32'h812c, k, m, polls = 0, tos = 0;
   usb_event_block dut_u (.i_clk(clk), .i_arst_n(arst_n), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_host_mode(host), .i_session_active(sess),
      .i_vbus_below_valid(ev[0]), .i_session_req_seen(ev[1]), .i_detach_seen(ev[2]),
      .i_session_end(ev[8]), .i_attach_seen(ev[3]), .i_frame_start(ev[4] | frame),
      .i_bus_reset_seen(ev[5] & !host), .i_babble_seen(ev[5] & host), .i_resume_seen(ev[6]),
      .i_suspend_seen(ev[7]), .i_rx_nak(nak), .i_rx_restart(restart), .o_rx_speed(speed),
      .o_rx_proto(proto), .o_rx_target_ep(tgt_ep), .o_rx_poll(poll), .o_rx_nak_timeout(nto),
      .o_usb_irq(usb_irq), .o_irq(irq));
   usb_peer_model peer_u (.i_clk(clk), .i_arst_n(arst_n), .i_fire(fire), .i_sel(sel),
      .i_frames(frames), .o_ev(ev), .o_frame(frame));
   always #25 clk = ~clk;
   // pulses counted on the falling edge, clear of the launch edge
   always @(negedge clk) begin
      polls = polls + (poll === 1'b1);
      tos = tos + (nto === 1'b1);
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done = checks_done + 1;
      if (g !== e) begin
         fail_count = fail_count + 1;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask
   // apb master: hold until pready, then release and let an edge pass
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic evt(input logic [3:0] s);
      fire <= 1'b1;
      sel <= s;
      @(posedge clk);
      fire <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   // ep < 0 skips the poll count; et is whether any timeout comes
   task automatic prun(input logic [15:0] c, input logic n, input integer ep, input logic et);
      integer p0, t0;
      apb(1'b1, 12'h004, {16'h0000, c}, 4'h3);
      p0 = polls;
      t0 = tos;
      restart <= 1'b1;
      nak <= n;
      @(posedge clk);
      restart <= 1'b0;
      frames <= 1'b1;
      repeat (48) @(posedge clk);
      frames <= 1'b0;
      repeat (4) @(posedge clk);
      nak <= 1'b0;
      if (ep >= 0) chk("polls", ep, polls - p0);
      chk("timeout", 32'(et), 32'(tos != t0));
      $display("poll test %h done", c);
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      #(50 * 6000);
      fail_count = fail_count + 1;
      end_sim;
   end
   initial begin
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      apb(1'b0, 12'h000, 32'h0000_0000, 4'h0);
      chk("ctrl_reset", 32'h0600_00FE, rd);
      en = 8'($random(seed));
      apb(1'b1, 12'h000, {en, 24'hFF_0000}, 4'hC);
      apb(1'b0, 12'h000, 32'h0000_0000, 4'h0);
      chk("enables", {en, 24'h00_00FE}, rd);
      en = 8'hFF;
      apb(1'b1, 12'h000, {en, 24'h00_0000}, 4'h8);
      for (m = 0; m < 2; m++) begin
         host <= m[0];
         for (k = 0; k < 9; k++) begin
            if ((k == 2 && m == 0) || (k == 8 && m == 1)) continue;
            xf = (k == 8) ? 8'h20 : 8'h80 >> k;
            if (k == 3 && m == 0) xf = 8'h00;
            evt(k[3:0]);
            chk("usb_irq", 32'(xf != 8'h00), 32'(usb_irq));
            apb(1'b0, 12'h000, 32'h0000_0000, 4'h0);
            chk("flags", {en, xf, 16'h00FE}, rd);
         end
         $display("event test mode %0d done", m);
      end
      // vbus below valid outside a session must not flag
      sess <= 1'b0;
      evt(4'h0);
      apb(1'b0, 12'h000, 32'h0000_0000, 4'h0);
      chk("vbus_idle", {en, 24'h00_00FE}, rd);
      sess <= 1'b1;
      apb(1'b1, 12'h00C, 32'h0000_0010, 4'h1);
      apb(1'b1, 12'h000, 32'hFB00_0000, 4'h8);
      // drop the event irq status left sticky by the loop above
      apb(1'b1, 12'h008, 32'h0000_001F, 4'h1);
      evt(4'h5);
      chk("gated_irq", 32'h0000_0000, {30'h0000_0000, usb_irq, irq});
      evt(4'h7);
      chk("irq", 32'h0000_0003, {30'h0000_0000, usb_irq, irq});
      apb(1'b0, 12'h000, 32'h0000_0000, 4'h0);
      apb(1'b1, 12'h008, 32'h0000_001F, 4'h1);
      chk("irq_clear", 32'h0000_0000, 32'(irq));
      apb(1'b1, 12'h00C, 32'h0000_0000, 4'h1);
      evt(4'h7);
      chk("irq_masked", 32'h0000_0000, 32'(irq));
      apb(1'b0, 12'h0FC, 32'h0000_0000, 4'h0);
      chk("unmapped_data", 32'h0000_0000, rd);
      chk("unmapped_err", 32'h0000_0001, 32'(er));
      $display("irq test done");
      for (k = 0; k < 4; k++) begin
         v = {24'h00_0000, k[1:0], ~k[1:0], 4'($random(seed))};
         apb(1'b1, 12'h004, v, 4'h3);
         chk("cfg_pins", v, {24'h00_0000, speed, proto, tgt_ep});
      end
      // reserved speed and zero interval on interrupt/iso stay sticky
      apb(1'b0, 12'h008, 32'h0000_0000, 4'h0);
      chk("irq_status", 32'h0000_001C, rd);
      apb(1'b1, 12'h008, 32'h0000_001F, 4'h1);
      $display("register test done");
      prun(16'h03F3, 1'b0, 4, 1'b0);
      prun(16'h0373, 1'b0, 3, 1'b0);
      prun(16'h0292, 1'b0, 6, 1'b0);
      prun(16'h0380, 1'b0, 0, 1'b0);
      prun(16'h0262, 1'b1, -1, 1'b1);
      prun(16'h0162, 1'b1, -1, 1'b0);
      // poll and nak timeout status bits, event irq still pending
      apb(1'b0, 12'h008, 32'h0000_0000, 4'h0);
      chk("poll_irq_status", 32'h0000_0013, rd);
      end_sim;
   end
endmodule // tb_top
`default_nettype wire

// >>> tb/usb_event_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================
// port checks for the event block
module usb_event_asserts (
   input wire logic        i_clk,
   input wire logic        i_arst_n,
   input wire logic        i_psel,
   input wire logic        i_penable,
   input wire logic        i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic        i_frame_start,
   input wire logic        i_rx_nak,
   input wire logic        o_pready,
   input wire logic        o_pslverr,
   input wire logic [1:0]  o_rx_speed,
   input wire logic [1:0]  o_rx_proto,
   input wire logic        o_rx_poll,
   input wire logic        o_rx_nak_timeout,
   input wire logic        o_usb_irq
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   // speed and protocol fields may only move after a config write
   wire cfg_wr = i_psel && i_penable && i_pwrite && i_paddr == 12'h004;
   ready_wait_a: assert property ($rose(i_penable) && i_psel |=> o_pready)
      else $error("pready not one wait state");
   ready_pulse_a: assert property (o_pready |=> !o_pready)
      else $error("pready longer than one cycle");
   err_ready_a: assert property (o_pslverr |-> o_pready)
      else $error("pslverr without pready");
   speed_copy_a: assert property ($changed(o_rx_speed) |-> $past(cfg_wr) || $past(cfg_wr, 2))
      else $error("speed moved without write");
   proto_copy_a: assert property ($changed(o_rx_proto) |-> $past(cfg_wr) || $past(cfg_wr, 2))
      else $error("protocol moved without write");
   poll_tick_a: assert property (o_rx_poll |-> $past(i_frame_start) || $past(i_frame_start, 2))
      else $error("poll without frame tick");
   ctrl_nopoll_a: assert property (o_rx_proto == 2'b00 |-> !o_rx_poll)
      else $error("control endpoint polled");
   nak_timeout_a: assert property (o_rx_nak_timeout |-> $past(i_rx_nak, 2) && o_rx_proto == 2'b10)
      else $error("timeout without bulk nak");
   cover property (o_rx_poll);
   cover property (o_rx_nak_timeout);
   cover property ($rose(o_usb_irq));
endmodule // usb_event_asserts
bind usb_event_block usb_event_asserts chk_u (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_psel(i_psel),
   .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_frame_start(i_frame_start),
   .i_rx_nak(i_rx_nak), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_rx_speed(o_rx_speed),
   .o_rx_proto(o_rx_proto), .o_rx_poll(o_rx_poll), .o_rx_nak_timeout(o_rx_nak_timeout), .o_usb_irq(o_usb_irq));
`default_nettype wire

// >>> tb/usb_peer_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================
// bus peer: event pulses and frame ticks
module usb_peer_model (
   input  wire logic       i_clk,
   input  wire logic       i_arst_n,
   input  wire logic       i_fire,
   input  wire logic [3:0] i_sel,
   input  wire logic       i_frames,
   output var  logic [8:0] o_ev,
   output var  logic       o_frame
);
   logic [1:0] div;
   // signalling shows as one-cycle pulses; frames stand still when off
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_ev <= 9'h000;
         div <= 2'b00;
         o_frame <= 1'b0;
      end else begin
         o_ev <= i_fire ? 9'h001 << i_sel : 9'h000;
         div <= i_frames ? div + 2'b01 : 2'b00;
         o_frame <= i_frames && div == 2'b11; // one frame every 4 cycles
      end
   end
endmodule // usb_peer_model
`default_nettype wire
